// file: csjg_pkg.sv
package csjg_pkg;
  localparam int IR_W = 10;
  localparam logic [9:0] SECURE_ENTRY_CODE = 10'h202;
  localparam logic [9:0] SECURE_EXIT_CODE = 10'h208;
  localparam int KEY_W = 128;
  localparam int ID_W = 64;
  localparam int ID_FETCH_CYCLES = 67;
  localparam int CNT_W = 7;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h04;
  localparam logic [5:0] ADDR_KEY0 = 6'h08;
  localparam logic [5:0] ADDR_KEY1 = 6'h0C;
  localparam logic [5:0] ADDR_KEY2 = 6'h10;
  localparam logic [5:0] ADDR_KEY3 = 6'h14;
  localparam logic [5:0] ADDR_ID_LO = 6'h18;
  localparam logic [5:0] ADDR_ID_HI = 6'h1C;
  localparam logic [5:0] ADDR_ERASE = 6'h20;
  localparam int CTRL_ENC_BIT = 0;
  localparam int CTRL_RBP_BIT = 1;
  localparam int CTRL_EOP_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int ST_SECURE_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_DENIED_BIT = 3;
  localparam int ERASE_BIT = 0;

  typedef enum logic [1:0] {
    CSJG_SEC_HEADER = 2'b00,
    CSJG_SEC_IOCHAIN = 2'b01,
    CSJG_SEC_CORE = 2'b10,
    CSJG_SEC_POST = 2'b11
  } csjg_section_t;

  typedef enum logic [1:0] {
    CSJG_OP_PROGRAM = 2'b00,
    CSJG_OP_ERASE = 2'b01,
    CSJG_OP_READ = 2'b10,
    CSJG_OP_VERIFY = 2'b11
  } csjg_flash_op_t;

  typedef enum logic [1:0] {
    CSJG_ID_IDLE = 2'b00,
    CSJG_ID_FETCH = 2'b01,
    CSJG_ID_DONE = 2'b10
  } csjg_id_state_t;
endpackage

// file: csjg_top.sv
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module csjg_top #(
  parameter logic [9:0] BYPASS_CODE = 10'h3FF,
  parameter logic [9:0] SAMPLE_CODE = 10'h005,
  parameter logic [9:0] EXTEST_CODE = 10'h00F,
  parameter logic [9:0] IDCODE_CODE = 10'h006,
  parameter logic [9:0] CONFIG_LOAD_CODE = 10'h002,
  // arbitrary identifier value, replaced per part
  parameter logic [63:0] DEVICE_UID = 64'h5A5A_0F0F_1234_ABCD,
  parameter int FETCH_CYCLES = csjg_pkg::ID_FETCH_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [5:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic IR_LOAD,
  input wire logic [9:0] IR_CODE,
  input wire logic IR_FROM_CORE,
  output logic [9:0] IR_ACTIVE,
  output logic IR_REFUSED,
  output logic SECURE_ACTIVE,
  input wire logic FLASH_REQ,
  input wire logic [1:0] FLASH_OP,
  output logic FLASH_GRANT,
  output logic FLASH_DENY,
  input wire logic [1:0] CFG_SECTION,
  input wire logic CFG_ENCRYPTED,
  input wire logic CFG_COMPRESSED,
  output logic DECRYPT_EN,
  output logic DECOMP_FROM_DECRYPT,
  output logic CFG_KEY_MISMATCH,
  output logic [127:0] CIPHER_KEY,
  input wire logic ID_READ_CLK,
  input wire logic ID_RESTART,
  output logic ID_READY,
  output logic [63:0] DEVICE_SERIAL_OUT
);
  if (FETCH_CYCLES < csjg_pkg::ID_FETCH_CYCLES ||
      FETCH_CYCLES > 127) begin : g_bad_cycles
    $error("FETCH_CYCLES out of range");
  end

  logic [2:0] ctrl;
  logic [127:0] key;
  logic refused_seen;
  logic denied_seen;
  logic enc_en;
  logic rbp_en;
  logic eop_en;
  logic ir_ok;
  logic is_lock;
  logic is_unlock;
  logic is_mand;
  logic erase_wr;

  assign enc_en = ctrl[csjg_pkg::CTRL_ENC_BIT];
  assign rbp_en = ctrl[csjg_pkg::CTRL_RBP_BIT];
  assign eop_en = ctrl[csjg_pkg::CTRL_EOP_BIT];
  assign erase_wr = WR && ADDR == csjg_pkg::ADDR_ERASE &&
    WDATA[csjg_pkg::ERASE_BIT];

  // instruction gate
  assign is_lock = IR_CODE == csjg_pkg::SECURE_ENTRY_CODE;
  assign is_unlock = IR_CODE == csjg_pkg::SECURE_EXIT_CODE;
  assign is_mand = IR_CODE == BYPASS_CODE || IR_CODE == SAMPLE_CODE ||
    IR_CODE == EXTEST_CODE || IR_CODE == IDCODE_CODE;

  always_comb begin
    if (is_lock || is_unlock) begin
      ir_ok = IR_FROM_CORE;
    end else if (SECURE_ACTIVE) begin
      ir_ok = is_mand;
    end else begin
      ir_ok = !(enc_en && IR_CODE == CONFIG_LOAD_CODE);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      SECURE_ACTIVE <= 1'b0;
    end else if (IR_LOAD && ir_ok && is_lock) begin
      SECURE_ACTIVE <= 1'b1;
    end else if (IR_LOAD && ir_ok && is_unlock) begin
      SECURE_ACTIVE <= 1'b0;
    end
  end

  // a refused code never reaches a data register other than bypass
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      IR_ACTIVE <= BYPASS_CODE;
      IR_REFUSED <= 1'b0;
    end else if (IR_LOAD) begin
      IR_ACTIVE <= ir_ok ? IR_CODE : BYPASS_CODE;
      IR_REFUSED <= !ir_ok;
    end
  end

  // flash permissions; secure mode denies the test port every flash operation
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      FLASH_GRANT <= 1'b0;
      FLASH_DENY <= 1'b0;
    end else begin
      FLASH_GRANT <= FLASH_REQ && !SECURE_ACTIVE &&
        (!rbp_en || !FLASH_OP[1]);
      FLASH_DENY <= FLASH_REQ && (SECURE_ACTIVE ||
        (rbp_en && FLASH_OP[1]));
    end
  end

  // configuration stream decryption
  logic chain_done;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      chain_done <= 1'b0;
    end else if (CFG_SECTION == csjg_pkg::CSJG_SEC_HEADER) begin
      chain_done <= 1'b0;
    end else if (CFG_SECTION == csjg_pkg::CSJG_SEC_CORE) begin
      chain_done <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      DECRYPT_EN <= 1'b0;
      DECOMP_FROM_DECRYPT <= 1'b0;
      CFG_KEY_MISMATCH <= 1'b0;
    end else begin
      DECRYPT_EN <= CFG_ENCRYPTED && CFG_SECTION[1] &&
        (chain_done || CFG_SECTION == csjg_pkg::CSJG_SEC_CORE);
      DECOMP_FROM_DECRYPT <= CFG_ENCRYPTED && CFG_COMPRESSED;
      CFG_KEY_MISMATCH <= SECURE_ACTIVE && eop_en &&
        !CFG_ENCRYPTED && CFG_SECTION[1];
    end
  end

  // key stays inside: only the cipher sees it
  assign CIPHER_KEY = key;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ctrl <= csjg_pkg::CTRL_RESET;
    end else if (erase_wr) begin
      ctrl <= csjg_pkg::CTRL_RESET;
    end else if (WR && ADDR == csjg_pkg::ADDR_CTRL) begin
      ctrl <= WDATA[2:0];
    end
  end

  // key models flash cells: no clear at reset, only at chip erase
  always_ff @(posedge CLOCK) begin
    if (erase_wr) begin
      key <= '0;
    end else if (WR && ADDR == csjg_pkg::ADDR_KEY0) begin
      key[31:0] <= WDATA;
    end else if (WR && ADDR == csjg_pkg::ADDR_KEY1) begin
      key[63:32] <= WDATA;
    end else if (WR && ADDR == csjg_pkg::ADDR_KEY2) begin
      key[95:64] <= WDATA;
    end else if (WR && ADDR == csjg_pkg::ADDR_KEY3) begin
      key[127:96] <= WDATA;
    end
  end

  // sticky events; a new event beats a write-one clear
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      refused_seen <= 1'b0;
      denied_seen <= 1'b0;
    end else begin
      if (IR_LOAD && !ir_ok) begin
        refused_seen <= 1'b1;
      end else if (WR && ADDR == csjg_pkg::ADDR_STATUS &&
          WDATA[csjg_pkg::ST_REFUSED_BIT]) begin
        refused_seen <= 1'b0;
      end
      if (FLASH_DENY) begin
        denied_seen <= 1'b1;
      end else if (WR && ADDR == csjg_pkg::ADDR_STATUS &&
          WDATA[csjg_pkg::ST_DENIED_BIT]) begin
        denied_seen <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      unique case (ADDR)
        csjg_pkg::ADDR_CTRL: RDATA <= {29'h0, ctrl};
        csjg_pkg::ADDR_STATUS: RDATA <= {28'h0, denied_seen,
          refused_seen, ID_READY, SECURE_ACTIVE};
        csjg_pkg::ADDR_ID_LO: RDATA <= DEVICE_SERIAL_OUT[31:0];
        csjg_pkg::ADDR_ID_HI: RDATA <= DEVICE_SERIAL_OUT[63:32];
        default: RDATA <= 32'h0000_0000;
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  // identifier reader: read clock is sampled, never used as a clock
  logic id_s1;
  logic id_s2;
  logic id_s3;
  logic id_lvl;
  logic id_edge;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      id_s1 <= 1'b0;
      id_s2 <= 1'b0;
      id_s3 <= 1'b0;
      id_lvl <= 1'b0;
    end else begin
      id_s1 <= ID_READ_CLK;
      id_s2 <= id_s1;
      id_s3 <= id_s2;
      if (id_s2 == id_s3) begin
        id_lvl <= id_s2;
      end
    end
  end
  assign id_edge = id_s2 == id_s3 && id_s2 && !id_lvl;

  csjg_pkg::csjg_id_state_t id_state;
  logic [6:0] id_cnt;
  logic [63:0] fuse_sh;
  logic [63:0] id_sh;
  logic [6:0] next_id_cnt;
  assign next_id_cnt = id_cnt + 7'h01;

  always_ff @(posedge CLOCK) begin
    if (!RST_N || ID_RESTART) begin
      id_state <= csjg_pkg::CSJG_ID_IDLE;
      id_cnt <= 7'h00;
      fuse_sh <= 64'h0;
      id_sh <= 64'h0;
      ID_READY <= 1'b0;
      DEVICE_SERIAL_OUT <= 64'h0;
    end else begin
      unique case (id_state)
        csjg_pkg::CSJG_ID_IDLE: if (id_edge) begin
          id_state <= csjg_pkg::CSJG_ID_FETCH;
          id_cnt <= 7'h01;
          fuse_sh <= {DEVICE_UID[62:0], 1'b0};
          id_sh <= {63'h0, DEVICE_UID[63]};
        end
        csjg_pkg::CSJG_ID_FETCH: if (id_edge) begin
          id_cnt <= next_id_cnt;
          if (id_cnt < 7'(csjg_pkg::ID_W)) begin
            id_sh <= {id_sh[62:0], fuse_sh[63]};
            fuse_sh <= {fuse_sh[62:0], 1'b0};
          end
          if (next_id_cnt == 7'(FETCH_CYCLES)) begin
            id_state <= csjg_pkg::CSJG_ID_DONE;
            ID_READY <= 1'b1;
            DEVICE_SERIAL_OUT <= id_sh;
          end
        end
        csjg_pkg::CSJG_ID_DONE: begin
          ID_READY <= 1'b1;
        end
        default: id_state <= csjg_pkg::CSJG_ID_IDLE;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  logic [7:0] edge_cnt;
  always_ff @(posedge CLOCK) begin
    if (!RST_N || ID_RESTART) begin
      edge_cnt <= 8'h00;
    end else if (id_edge && !ID_READY && edge_cnt != 8'hFF) begin
      edge_cnt <= edge_cnt + 8'h01;
    end
  end

  a_lock_core_only: assert property (
    IR_LOAD && !IR_FROM_CORE && (is_lock || is_unlock) |=>
      IR_REFUSED && $stable(SECURE_ACTIVE))
    else $error("entry/exit accepted from pins");
  a_secure_entry: assert property (
    IR_LOAD && IR_FROM_CORE && is_lock |=> SECURE_ACTIVE)
    else $error("secure entry failed");
  a_secure_exit: assert property (
    IR_LOAD && IR_FROM_CORE && is_unlock |=> !SECURE_ACTIVE)
    else $error("secure exit failed");
  a_secure_refuse: assert property (
    IR_LOAD && SECURE_ACTIVE && !is_mand && !is_lock && !is_unlock
      |=> IR_REFUSED && IR_ACTIVE == BYPASS_CODE)
    else $error("non-mandatory ran in secure mode");
  a_enc_cfgload: assert property (
    IR_LOAD && !SECURE_ACTIVE && IR_CODE == CONFIG_LOAD_CODE
      |=> IR_REFUSED == $past(enc_en))
    else $error("config load gating wrong");
  a_open_accept: assert property (
    IR_LOAD && !SECURE_ACTIVE && !enc_en && !is_lock && !is_unlock
      |=> !IR_REFUSED && IR_ACTIVE == $past(IR_CODE))
    else $error("unsecured instruction refused");
  a_flash_rbp: assert property (
    FLASH_REQ && rbp_en && FLASH_OP[1] |=> FLASH_DENY && !FLASH_GRANT)
    else $error("read-back allowed under protect");
  a_decrypt_sections: assert property (
    !CFG_SECTION[1] |=> !DECRYPT_EN)
    else $error("plaintext section decrypted");
  a_id_ready_min: assert property (
    $rose(ID_READY) |-> edge_cnt >= 8'(csjg_pkg::ID_FETCH_CYCLES))
    else $error("identifier ready too early");
  a_id_hold: assert property (
    ID_READY && !ID_RESTART |=> ID_READY && $stable(DEVICE_SERIAL_OUT))
    else $error("identifier changed while held");
  a_key_hidden: assert property (
    $past(RD) && $past(ADDR) >= csjg_pkg::ADDR_KEY0 &&
      $past(ADDR) <= csjg_pkg::ADDR_KEY3 |-> RDATA == 32'h0000_0000)
    else $error("key visible on read port");
  a_erase_key: assert property (
    erase_wr |=> key == '0 && ctrl == csjg_pkg::CTRL_RESET)
    else $error("erase left key or settings");
  // config load is never mandatory, so secure mode must refuse it
  a_cfgload_secure: assert property (
    IR_LOAD && SECURE_ACTIVE && IR_CODE == CONFIG_LOAD_CODE |=> IR_REFUSED)
    else $error("config load ran in secure mode");
  a_refused_bypass: assert property (
    IR_LOAD ##1 IR_REFUSED |->
      IR_ACTIVE == BYPASS_CODE && $stable(SECURE_ACTIVE))
    else $error("refused code changed state");
  a_flash_secure: assert property (
    FLASH_REQ && SECURE_ACTIVE |=> FLASH_DENY && !FLASH_GRANT)
    else $error("flash reachable in secure mode");
  a_decomp_order: assert property (
    CFG_ENCRYPTED && CFG_COMPRESSED |=> DECOMP_FROM_DECRYPT)
    else $error("decompressor not fed by decryptor");
  a_plain_reject: assert property (
    SECURE_ACTIVE && eop_en && !CFG_ENCRYPTED && CFG_SECTION[1]
      |=> CFG_KEY_MISMATCH)
    else $error("plaintext image not rejected");
  // ready must never rise ahead of the full identifier
  a_id_valid: assert property (
    $rose(ID_READY) |-> DEVICE_SERIAL_OUT == DEVICE_UID)
    else $error("identifier not valid at ready");

  c_lock_unlock: cover property (
    IR_LOAD && is_lock && IR_FROM_CORE ##[1:50] IR_LOAD && is_unlock);
  c_id_done: cover property ($rose(ID_READY));
  c_flash_deny: cover property (FLASH_DENY);
  c_decrypt: cover property ($rose(DECRYPT_EN));
endmodule

// file: csjg_id_clk_src.sv
`timescale 1ns/1ps
// user logic clocking the identifier reader, 160 ns period
module csjg_id_clk_src (
  input wire logic enable,
  output logic read_clk,
  output int n_edges
);
  initial begin
    read_clk = 1'b0;
    n_edges = 0;
    // odd offset keeps it out of phase with the system clock
    #3;
    forever begin
      #80;
      if (enable) begin
        read_clk = ~read_clk;
        if (read_clk) n_edges++;
      end else begin
        read_clk = 1'b0;
      end
    end
  end
endmodule

// file: csjg_top_tb.sv
`timescale 1ns/1ps
module csjg_top_tb;
  localparam logic [9:0] BYP = 10'h3FF;
  localparam logic [9:0] SMP = 10'h005;
  localparam logic [9:0] EXT = 10'h00F;
  localparam logic [9:0] IDC = 10'h006;
  localparam logic [9:0] CFG = 10'h002;
  // arbitrary identifier value
  localparam logic [63:0] UID = 64'h3C96_7E01_A5D2_4B18;
  localparam logic [9:0] ENT = csjg_pkg::SECURE_ENTRY_CODE;
  localparam logic [9:0] EXI = csjg_pkg::SECURE_EXIT_CODE;
  logic clock, rst_n, wr, rd, ir_load, ir_from_core, ir_refused;
  logic secure_active, flash_req, flash_grant, flash_deny;
  logic cfg_encrypted, cfg_compressed, decrypt_en, decomp_from_decrypt;
  logic cfg_key_mismatch, id_read_clk, id_restart, id_ready, id_run;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [9:0] ir_code, ir_active;
  logic [1:0] flash_op, cfg_section;
  logic [127:0] cipher_key;
  logic [63:0] device_serial_out;
  int n_mismatch = 0, n_compared = 0, cycles = 0, e0, i;
  logic [9:0] codes [6] = '{SMP, BYP, EXT, IDC, CFG, 10'h0AA};

  csjg_top #(.BYPASS_CODE(BYP), .SAMPLE_CODE(SMP), .EXTEST_CODE(EXT),
    .IDCODE_CODE(IDC), .CONFIG_LOAD_CODE(CFG), .DEVICE_UID(UID),
    .FETCH_CYCLES(67)) csjg_top_inst (.CLOCK(clock), .RST_N(rst_n),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .IR_LOAD(ir_load), .IR_CODE(ir_code), .IR_FROM_CORE(ir_from_core),
    .IR_ACTIVE(ir_active), .IR_REFUSED(ir_refused),
    .SECURE_ACTIVE(secure_active), .FLASH_REQ(flash_req),
    .FLASH_OP(flash_op), .FLASH_GRANT(flash_grant),
    .FLASH_DENY(flash_deny), .CFG_SECTION(cfg_section),
    .CFG_ENCRYPTED(cfg_encrypted), .CFG_COMPRESSED(cfg_compressed),
    .DECRYPT_EN(decrypt_en), .DECOMP_FROM_DECRYPT(decomp_from_decrypt),
    .CFG_KEY_MISMATCH(cfg_key_mismatch), .CIPHER_KEY(cipher_key),
    .ID_READ_CLK(id_read_clk), .ID_RESTART(id_restart),
    .ID_READY(id_ready), .DEVICE_SERIAL_OUT(device_serial_out));
  csjg_id_clk_src csjg_id_clk_src_inst (.enable(id_run),
    .read_clk(id_read_clk), .n_edges(e0));

  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    // the whole run needs under two thousand cycles
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrt(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic [5:0] a, output logic [31:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic ir(input logic [9:0] c, input logic core,
    input logic ref_exp, input logic sec_exp);
    @(posedge clock);
    ir_load <= 1'b1;
    ir_code <= c;
    ir_from_core <= core;
    @(posedge clock);
    ir_load <= 1'b0;
    #1;
    chk(ir_refused, ref_exp);
    chk(ir_active, ref_exp ? BYP : c);
    chk(secure_active, sec_exp);
  endtask
  task automatic fl(input logic [1:0] op, input logic ok);
    @(posedge clock);
    flash_req <= 1'b1;
    flash_op <= op;
    @(posedge clock);
    flash_req <= 1'b0;
    #1;
    chk({flash_grant, flash_deny}, {ok, !ok});
  endtask
  task automatic st(input logic [1:0] s, input logic exp);
    @(posedge clock);
    cfg_section <= s;
    repeat (2) @(posedge clock);
    #1;
    chk(decrypt_en, exp);
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    {clock, rst_n, wr, rd, ir_load, ir_from_core, flash_req} = '0;
    {cfg_encrypted, cfg_compressed, id_restart, id_run} = '0;
    {addr, wdata, ir_code, flash_op, cfg_section} = '0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk({ir_active, secure_active, id_ready}, {BYP, 2'b00});
    wrt(csjg_pkg::ADDR_ERASE, 32'h1);
    chk(cipher_key, 128'h0);
    wrt(csjg_pkg::ADDR_KEY0, 32'hC3A5_0F1E);
    chk(cipher_key, 128'hC3A5_0F1E);
    wrt(csjg_pkg::ADDR_KEY3, 32'h1E0F_A5C3);
    chk(cipher_key, {32'h1E0F_A5C3, 64'h0, 32'hC3A5_0F1E});
    rdr(csjg_pkg::ADDR_KEY0, v);
    chk(v, 32'h0);
    rdr(6'h3C, v);
    chk(v, 32'h0);
    wrt(csjg_pkg::ADDR_CTRL, 32'h7);
    wrt(csjg_pkg::ADDR_ERASE, 32'h1);
    chk(cipher_key, 128'h0);
    rdr(csjg_pkg::ADDR_CTRL, v);
    chk(v, 32'h0);
    $display("test registers done");
    ir(CFG, 1'b0, 1'b0, 1'b0);
    wrt(csjg_pkg::ADDR_CTRL, 32'h1);
    ir(CFG, 1'b0, 1'b1, 1'b0);
    ir(ENT, 1'b0, 1'b1, 1'b0);
    ir(ENT, 1'b1, 1'b0, 1'b1);
    for (i = 0; i < 6; i++) ir(codes[i], 1'b0, i > 3, 1'b1);
    ir(EXI, 1'b0, 1'b1, 1'b1);
    ir(EXI, 1'b1, 1'b0, 1'b0);
    ir(10'h0AA, 1'b0, 1'b0, 1'b0);
    rdr(csjg_pkg::ADDR_STATUS, v);
    chk(v[csjg_pkg::ST_REFUSED_BIT], 1'b1);
    $display("test instruction gate done");
    wrt(csjg_pkg::ADDR_CTRL, 32'h2);
    for (i = 0; i < 4; i++) fl(i[1:0], i < 2);
    ir(ENT, 1'b1, 1'b0, 1'b1);
    for (i = 0; i < 4; i++) fl(i[1:0], 1'b0);
    ir(EXI, 1'b1, 1'b0, 1'b0);
    rdr(csjg_pkg::ADDR_STATUS, v);
    chk(v[3:0], 4'hC);
    wrt(csjg_pkg::ADDR_STATUS, 32'hC);
    rdr(csjg_pkg::ADDR_STATUS, v);
    chk(v[3:0], 4'h0);
    $display("test flash done");
    wrt(csjg_pkg::ADDR_CTRL, 32'h0);
    @(posedge clock);
    cfg_encrypted <= 1'b1;
    cfg_compressed <= 1'b1;
    st(csjg_pkg::CSJG_SEC_HEADER, 1'b0);
    st(csjg_pkg::CSJG_SEC_IOCHAIN, 1'b0);
    st(csjg_pkg::CSJG_SEC_CORE, 1'b1);
    chk({decomp_from_decrypt, cfg_key_mismatch}, 2'b10);
    st(csjg_pkg::CSJG_SEC_POST, 1'b1);
    @(posedge clock);
    cfg_encrypted <= 1'b0;
    wrt(csjg_pkg::ADDR_CTRL, 32'h4);
    ir(ENT, 1'b1, 1'b0, 1'b1);
    st(csjg_pkg::CSJG_SEC_HEADER, 1'b0);
    st(csjg_pkg::CSJG_SEC_CORE, 1'b0);
    chk(cfg_key_mismatch, 1'b1);
    chk(decomp_from_decrypt, 1'b0);
    ir(EXI, 1'b1, 1'b0, 1'b0);
    $display("test stream done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      i = e0;
      id_run <= 1'b1;
      for (int w = 0; w < 1000 && id_ready !== 1'b1; w++) @(posedge clock);
      #1;
      chk(id_ready, 1'b1);
      chk(e0 - i >= 67, 1'b1);
      chk(device_serial_out, UID);
      repeat (100) @(posedge clock);
      chk({id_ready, device_serial_out}, {1'b1, UID});
      rdr(csjg_pkg::ADDR_ID_HI, v);
      chk(v, UID[63:32]);
      rdr(csjg_pkg::ADDR_ID_LO, v);
      chk(v, UID[31:0]);
      rdr(csjg_pkg::ADDR_STATUS, v);
      chk(v[1:0], 2'b10);
      @(posedge clock);
      id_run <= 1'b0;
      id_restart <= 1'b1;
      @(posedge clock);
      id_restart <= 1'b0;
      repeat (100) @(posedge clock);
      chk(id_ready, 1'b0);
    end
    $display("test identifier done");
    conclude();
  end
endmodule
